/* inc/rtc_ctrl_pkg.sv */
/*
  constants, field layout and bus carrier types for the rtc control and
  status block.
  assumes: a single 32-bit ahb-lite slave port, word accesses only,
  and neighbouring counter and unlock units that supply the status inputs.
*/
// Operation
// - value registers writable only while unlocked
// - unlock sets only during sequence; clears anytime
// - hazard bit shows possible rollover ripple
// - read-only phase bit marks second half
// - seconds write clears the phase bit
// - clock pin driven only when enabled and on
// - control register reset only at power-on
`default_nettype none
package rtc_ctrl_pkg;
  // ==========================================================
  // register map (byte addresses, low bits of haddr)
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIME_OFS = 8'h10;
  localparam logic [7:0] DATE_OFS = 8'h20;
  // ==========================================================
  // control word field positions
  localparam int CAL_LO = 16;
  localparam int CAL_W = 10;
  localparam int ON_BIT = 15;
  localparam int FRZ_BIT = 14;
  localparam int SIDL_BIT = 13;
  localparam int SECSEL_BIT = 7;
  localparam int CLKON_BIT = 6;
  localparam int UNLOCK_BIT = 3;
  localparam int HAZARD_BIT = 2;
  localparam int HALF_BIT = 1;
  localparam int OE_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // ==========================================================
  // bus phase tracking
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } bus_phase_t;
  // one register access, as seen by the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

/* design/ahb_reg_port.sv */
/*
  ahb-lite slave front end: turns address and data phases into one
  register request per transfer.
  assumes: single word transfers, one slave on the bus, hready fed back
  from this slave's hreadyout.
*/
`default_nettype none
module ahb_reg_port (
  // clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  // register side
  output rtc_ctrl_pkg::reg_req_t req
);
  // ==========================================================
  // address phase capture
  rtc_ctrl_pkg::bus_phase_t phase_q; // what the current data phase is
  logic [rtc_ctrl_pkg::ADDR_W-1:0] addr_q; // captured register address
  logic ready_q; // drives hreadyout
  logic start; // a transfer's address phase is taken

  // nonseq or seq both count; only htrans[1] matters
  assign start = hsel && htrans[1] && hready;

  // phase tracker: reads take one wait state so read data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= rtc_ctrl_pkg::PH_IDLE;
      addr_q <= '0;
      ready_q <= 1'b1;
    end else if (start) begin
      addr_q <= haddr[rtc_ctrl_pkg::ADDR_W-1:0];
      phase_q <= hwrite ? rtc_ctrl_pkg::PH_WRITE : rtc_ctrl_pkg::PH_READ;
      ready_q <= hwrite; // stretch only reads
    end else begin
      // read wait ends here; writes finish with zero wait
      phase_q <= rtc_ctrl_pkg::PH_IDLE;
      ready_q <= 1'b1;
    end
  end

  // response is always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign hreadyout = ready_q;

  // request out: write during write data phase, read fetch in the wait cycle
  always_comb begin
    req.wr = (phase_q == rtc_ctrl_pkg::PH_WRITE);
    req.rd = (phase_q == rtc_ctrl_pkg::PH_READ);
    req.addr = addr_q;
    req.wdata = hwdata;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_read_one_wait;
    start && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_one_wait: assert property (p_read_one_wait) else $error("read wait state wrong");

  property p_write_no_wait;
    start && hwrite |=> hreadyout && req.wr;
  endproperty
  a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled");
endmodule
`default_nettype wire

/* design/rtc_control_status.sv */
/*
  control and status logic of the real-time clock: control register,
  value-register write lock, rollover read hazard flag, half-second phase,
  and gating of the clock output pin.
  assumes: hresetn is the power-on reset; other resets arrive on
  soft_reset; counter, prescaler and unlock units are neighbours that
  drive the status inputs synchronously to hclk.
*/
`default_nettype none
module rtc_control_status (
  // clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // system status and non-power-on reset
  input wire logic soft_reset,
  input wire logic debug_mode,
  input wire logic cpu_idle,
  // from the unlock sequencer
  input wire logic unlock_seq_active,
  // from the counters and prescaler
  input wire logic half_tick,
  input wire logic rollover_ripple,
  input wire logic alarm_pulse,
  input wire logic [31:0] time_value,
  input wire logic [31:0] date_value,
  // to the counters
  output logic time_advance_en,
  output logic value_wr,
  output logic value_sel_date,
  output logic [31:0] value_wdata,
  output logic [9:0] drift_cal,
  // clock output pin
  output logic clk_out,
  output logic clk_out_en
);
  // ==========================================================
  // bus front end
  rtc_ctrl_pkg::reg_req_t req; // one access per transfer
  logic unused_size; // only word transfers are expected

  assign unused_size = ^hsize;

  ahb_reg_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(req)
  );

  // ==========================================================
  // decode
  logic wr_ctrl; // write to control word
  logic wr_value; // write aimed at time or date
  logic wr_value_ok; // that write while unlocked
  logic wr_time_ok; // accepted time write, holds seconds
  logic unlock_q; // value write unlock, declared here because the decode reads it

  // address decode, unmapped writes fall through and are ignored
  always_comb begin
    wr_ctrl = 1'b0;
    wr_value = 1'b0;
    if (req.addr == rtc_ctrl_pkg::CTRL_OFS) begin
      wr_ctrl = req.wr;
    end else if (req.addr == rtc_ctrl_pkg::TIME_OFS) begin
      wr_value = req.wr;
    end else if (req.addr == rtc_ctrl_pkg::DATE_OFS) begin
      wr_value = req.wr;
    end
  end

  assign wr_value_ok = wr_value && unlock_q;
  assign wr_time_ok = wr_value_ok && (req.addr == rtc_ctrl_pkg::TIME_OFS);

  // ==========================================================
  // control word storage, power-on reset only
  logic [9:0] cal_q; // drift calibration, passed on
  logic on_q; // module enable
  logic frz_q; // freeze request in debug
  logic sidl_q; // stop while cpu idles
  logic secsel_q; // 1 = seconds clock on pin, 0 = alarm pulse
  logic oe_q; // clock output enable
  logic clk_running_q; // read-only echo of running state

  // plain fields; soft_reset is deliberately not looked at here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_q <= rtc_ctrl_pkg::CTRL_RESET[rtc_ctrl_pkg::CAL_LO +: rtc_ctrl_pkg::CAL_W];
      frz_q <= rtc_ctrl_pkg::CTRL_RESET[rtc_ctrl_pkg::FRZ_BIT];
      sidl_q <= rtc_ctrl_pkg::CTRL_RESET[rtc_ctrl_pkg::SIDL_BIT];
      secsel_q <= rtc_ctrl_pkg::CTRL_RESET[rtc_ctrl_pkg::SECSEL_BIT];
      oe_q <= rtc_ctrl_pkg::CTRL_RESET[rtc_ctrl_pkg::OE_BIT];
    end else if (wr_ctrl) begin
      cal_q <= req.wdata[rtc_ctrl_pkg::CAL_LO +: rtc_ctrl_pkg::CAL_W];
      frz_q <= req.wdata[rtc_ctrl_pkg::FRZ_BIT];
      sidl_q <= req.wdata[rtc_ctrl_pkg::SIDL_BIT];
      secsel_q <= req.wdata[rtc_ctrl_pkg::SECSEL_BIT];
      oe_q <= req.wdata[rtc_ctrl_pkg::OE_BIT];
    end
  end

  // enable bit: guarded like the value registers, so a stray write cannot stop time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_q <= rtc_ctrl_pkg::CTRL_RESET[rtc_ctrl_pkg::ON_BIT];
    end else if (wr_ctrl && unlock_q) begin
      on_q <= req.wdata[rtc_ctrl_pkg::ON_BIT];
    end
  end

  // unlock bit: clearing always works, setting needs the sequence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unlock_q <= rtc_ctrl_pkg::CTRL_RESET[rtc_ctrl_pkg::UNLOCK_BIT];
    end else if (wr_ctrl) begin
      if (!req.wdata[rtc_ctrl_pkg::UNLOCK_BIT]) begin
        unlock_q <= 1'b0;
      end else if (unlock_seq_active) begin
        unlock_q <= 1'b1;
      end
    end
  end

  // running echo lags the enable by a cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_running_q <= 1'b0;
    end else begin
      clk_running_q <= on_q;
    end
  end

  // ==========================================================
  // status flags
  logic hazard_q; // rollover may ripple through a read
  logic half_q; // second half of the current second

  // hazard follows the counters' ripple window; no ripple while off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hazard_q <= 1'b0;
    end else begin
      hazard_q <= on_q && rollover_ripple;
    end
  end

  // phase flips on each half tick while on; a seconds write restarts the second,
  // so the clear beats a coincident tick rather than losing the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_q <= 1'b0;
    end else if (wr_time_ok) begin
      half_q <= 1'b0;
    end else if (half_tick && on_q) begin
      half_q <= ~half_q;
    end
  end

  // ==========================================================
  // value register write path, pipelined to the counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_wr <= 1'b0;
      value_sel_date <= 1'b0;
      value_wdata <= rtc_ctrl_pkg::RDATA_ZERO;
    end else begin
      value_wr <= wr_value_ok && !soft_reset;
      value_sel_date <= (req.addr == rtc_ctrl_pkg::DATE_OFS);
      value_wdata <= req.wdata;
    end
  end

  // ==========================================================
  // counter control and clock pin
  logic pin_src; // chosen clock source for the pin

  assign pin_src = secsel_q ? half_q : alarm_pulse;

  // time only advances while on, not frozen in debug, not idled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_advance_en <= 1'b0;
      drift_cal <= '0;
    end else begin
      time_advance_en <= on_q && !(frz_q && debug_mode) && !(sidl_q && cpu_idle);
      drift_cal <= cal_q;
    end
  end

  // pin gate: output enable is the and of both bits, data held low when off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out <= 1'b0;
      clk_out_en <= 1'b0;
    end else begin
      clk_out_en <= on_q && oe_q;
      clk_out <= on_q && pin_src;
    end
  end

  // ==========================================================
  // read back
  logic [31:0] ctrl_word; // control word as software sees it

  // freeze reads zero outside debug; unused bits read zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[rtc_ctrl_pkg::CAL_LO +: rtc_ctrl_pkg::CAL_W] = cal_q;
    ctrl_word[rtc_ctrl_pkg::ON_BIT] = on_q;
    ctrl_word[rtc_ctrl_pkg::FRZ_BIT] = frz_q && debug_mode;
    ctrl_word[rtc_ctrl_pkg::SIDL_BIT] = sidl_q;
    ctrl_word[rtc_ctrl_pkg::SECSEL_BIT] = secsel_q;
    ctrl_word[rtc_ctrl_pkg::CLKON_BIT] = clk_running_q;
    ctrl_word[rtc_ctrl_pkg::UNLOCK_BIT] = unlock_q;
    ctrl_word[rtc_ctrl_pkg::HAZARD_BIT] = hazard_q;
    ctrl_word[rtc_ctrl_pkg::HALF_BIT] = half_q;
    ctrl_word[rtc_ctrl_pkg::OE_BIT] = oe_q;
  end

  // read data taken in the wait cycle; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= rtc_ctrl_pkg::RDATA_ZERO;
    end else if (req.rd) begin
      if (req.addr == rtc_ctrl_pkg::CTRL_OFS) begin
        hrdata <= ctrl_word;
      end else if (req.addr == rtc_ctrl_pkg::TIME_OFS) begin
        hrdata <= time_value;
      end else if (req.addr == rtc_ctrl_pkg::DATE_OFS) begin
        hrdata <= date_value;
      end else begin
        hrdata <= rtc_ctrl_pkg::RDATA_ZERO;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_locked_write_blocked;
    wr_value && !unlock_q |=> !value_wr;
  endproperty
  a_locked_write_blocked: assert property (p_locked_write_blocked)
    else $error("value write passed while locked");

  property p_unlock_needs_seq;
    !unlock_q && !unlock_seq_active |=> !unlock_q;
  endproperty
  a_unlock_needs_seq: assert property (p_unlock_needs_seq)
    else $error("unlock set without sequence");

  property p_unlock_clear;
    wr_ctrl && !req.wdata[rtc_ctrl_pkg::UNLOCK_BIT] |=> !unlock_q ##1 !value_wr;
  endproperty
  a_unlock_clear: assert property (p_unlock_clear)
    else $error("unlock clear ignored");

  property p_hazard_tracks;
    on_q && rollover_ripple |=> hazard_q && ctrl_word[rtc_ctrl_pkg::HAZARD_BIT];
  endproperty
  a_hazard_tracks: assert property (p_hazard_tracks)
    else $error("hazard bit missed ripple");

  property p_phase_toggles;
    half_tick && on_q && !wr_time_ok |=> half_q != $past(half_q);
  endproperty
  a_phase_toggles: assert property (p_phase_toggles)
    else $error("phase did not toggle");

  property p_seconds_clear;
    wr_time_ok |=> !half_q;
  endproperty
  a_seconds_clear: assert property (p_seconds_clear)
    else $error("seconds write kept phase");

  property p_pin_gate;
    clk_out_en |-> $past(on_q) && $past(oe_q);
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("pin driven while gated off");

  property p_soft_reset_keeps;
    soft_reset && !wr_ctrl |=> $stable(ctrl_word[rtc_ctrl_pkg::ON_BIT]) && $stable(cal_q) && $stable(oe_q);
  endproperty
  a_soft_reset_keeps: assert property (p_soft_reset_keeps)
    else $error("control lost on soft reset");

  property p_off_stops;
    !on_q [*2] |-> !time_advance_en && !clk_out && !clk_out_en;
  endproperty
  a_off_stops: assert property (p_off_stops)
    else $error("time or pin active while off");

  c_unlock_then_write: cover property (unlock_q && wr_value ##1 value_wr);
  c_seconds_write_clears: cover property (half_q && wr_time_ok);
  c_pin_enabled: cover property (clk_out_en && clk_out);
  c_hazard_read: cover property (hazard_q && req.rd);
endmodule
`default_nettype wire

/* sim/test_rtc_control_status.sv */
/*
  self-checking bench for the rtc control and status block: ahb-lite
  master tasks, directed sequences and a verdict.
  assumes: the design holds its own assertions; hready is fed from this
  slave's hreadyout; hresetn is the power-on reset.
*/
`default_nettype none
module test_rtc_control_status;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // clock, reset and stimulus
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b000;
  logic alarm_pulse = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic soft_reset = 1'b0;
  logic unlock_seq_active = 1'b0;
  logic half_tick = 1'b0;
  logic rollover_ripple = 1'b0;
  logic [31:0] time_value = 32'h0012_3456;
  logic [31:0] date_value = 32'h0024_0615;
  // design outputs
  logic hreadyout, hresp, time_advance_en, value_wr, value_sel_date, clk_out, clk_out_en;
  logic [31:0] hrdata, value_wdata;
  logic [9:0] drift_cal;
  // bookkeeping
  int error_cnt = 0;
  int compares = 0;
  int wr_cnt = 0;
  logic wr_sel;
  logic [31:0] wr_data;
  logic [31:0] rd;
  logic [31:0] rd2;
  // addresses as full bus words
  localparam logic [31:0] A_CTRL = {24'h00_0000, rtc_ctrl_pkg::CTRL_OFS};
  localparam logic [31:0] A_TIME = {24'h00_0000, rtc_ctrl_pkg::TIME_OFS};
  localparam logic [31:0] A_DATE = {24'h00_0000, rtc_ctrl_pkg::DATE_OFS};
  localparam logic [31:0] A_NONE = 32'h0000_000c;

  always #50 hclk = ~hclk;

  rtc_control_status rtc_control_status_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .soft_reset(soft_reset), .debug_mode(1'b0), .cpu_idle(1'b0),
    .unlock_seq_active(unlock_seq_active), .half_tick(half_tick), .rollover_ripple(rollover_ripple),
    .alarm_pulse(alarm_pulse), .time_value(time_value), .date_value(date_value),
    .time_advance_en(time_advance_en), .value_wr(value_wr), .value_sel_date(value_sel_date),
    .value_wdata(value_wdata), .drift_cal(drift_cal), .clk_out(clk_out), .clk_out_en(clk_out_en)
  );

  // ==========================================================
  // value-write monitor: counts accepted time/date writes
  always @(posedge hclk) begin
    if (value_wr === 1'b1) begin
      wr_cnt++;
      wr_sel = value_sel_date;
      wr_data = value_wdata;
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single ahb-lite transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge hclk);
    // address phase held until hready seen high
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    // data phase held until hready seen high; read data taken here
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic rdw(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask

  // control word image; clock-running bit follows the on bit
  function automatic logic [31:0] ctl(input logic on, input logic unl, input logic oe, input logic hf,
                                      input logic hz);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[rtc_ctrl_pkg::ON_BIT] = on;
    v[rtc_ctrl_pkg::CLKON_BIT] = on;
    v[rtc_ctrl_pkg::UNLOCK_BIT] = unl;
    v[rtc_ctrl_pkg::HAZARD_BIT] = hz;
    v[rtc_ctrl_pkg::HALF_BIT] = hf;
    v[rtc_ctrl_pkg::OE_BIT] = oe;
    return v;
  endfunction

  task automatic pulse_half();
    half_tick <= 1'b1;
    @(posedge hclk);
    half_tick <= 1'b0;
    tick(3);
  endtask

  task summarize();
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole sequence needs about 130 cycles
  initial begin
    tick(20000);
    error_cnt++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial begin
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    rdw(A_CTRL, rd);
    check(rd, 32'h0000_0000);
    // setting unlock outside the sequence is refused, so is the on bit; oe is a plain field
    wr(A_CTRL, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    // locked time write never reaches the counters
    wr(A_TIME, 32'h0001_0203);
    tick(2);
    check(wr_cnt, 0);
    // every on/oe pairing with the sequence open
    unlock_seq_active <= 1'b1;
    alarm_pulse <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, ctl(i[1], 1'b1, i[0], 1'b0, 1'b0));
      tick(3);
      check(clk_out_en, i[1] & i[0]);
      check(clk_out, i[1]);
      check(time_advance_en, i[1]);
      rdw(A_CTRL, rd);
      check(rd, ctl(i[1], 1'b1, i[0], 1'b0, 1'b0));
    end
    unlock_seq_active <= 1'b0;
    alarm_pulse <= 1'b0;
    // unlocked writes go through to time and then to date, with an idle address phase between them
    wr(A_TIME, 32'h0011_2233);
    wr(A_DATE, 32'h0024_1231);
    tick(2);
    check(wr_cnt, 2);
    check(wr_sel, 1'b1);
    check(wr_data, 32'h0024_1231);
    // phase bit toggles on each half tick
    pulse_half();
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
    pulse_half();
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    pulse_half();
    // seconds write restarts the second
    wr(A_TIME, 32'h0011_2234);
    tick(2);
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    check(wr_data, 32'h0011_2234);
    // hazard flag follows rollover ripple; reader retries until two reads match
    rollover_ripple <= 1'b1;
    tick(3);
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
    rdw(A_TIME, rd);
    rdw(A_TIME, rd2);
    while (rd !== rd2) begin
      rd = rd2;
      rdw(A_TIME, rd2);
    end
    check(rd2, 32'h0012_3456);
    rollover_ripple <= 1'b0;
    tick(3);
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    // a non-power-on reset leaves the control register alone
    soft_reset <= 1'b1;
    tick(2);
    soft_reset <= 1'b0;
    tick(1);
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    check(clk_out_en, 1'b1);
    // unlock clears with the sequence closed, then writes are blocked again
    wr(A_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    wr(A_TIME, 32'h0000_0001);
    tick(2);
    check(wr_cnt, 3);
    // reads of value and unmapped places
    rdw(A_DATE, rd);
    check(rd, 32'h0024_0615);
    rdw(A_NONE, rd);
    check(rd, 32'h0000_0000);
    check(hresp, 1'b0);
    // calibration passes through; seconds phase selected onto the pin
    wr(A_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0) | 32'h0155_0080);
    pulse_half();
    check(drift_cal, 10'h155);
    check(clk_out, 1'b1);
    rdw(A_CTRL, rd);
    check(rd, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b0) | 32'h0155_0080);
    summarize();
  end
endmodule
`default_nettype wire
